// [hdl/adc_power_mode_control.sv]
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module adc_power_mode_control #(
    parameter int REF_SETTLE_CYC = adc_pkg::REF_SETTLE_CYC
) (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CE,
    // Serial pins
    input wire logic CS_B,
    input wire logic SCLK,
    input wire logic DIN,
    input wire logic HARDWARE_SHUTDOWN_N,
    output logic DOUT,
    output logic DOUT_OE_N,
    output logic CONVERSION_STROBE,
    // Converter core
    input wire logic [adc_pkg::CODE_BITS-1:0] ANALOG_CODE,
    output logic [2:0] CHANNEL_SELECT,
    output logic POLARITY_SELECT,
    output logic INPUT_CONFIG_SELECT,
    output logic FULLY_POWERED,
    output logic [1:0] COMPARATOR_POWER,
    output logic REFERENCE_ON,
    output logic CONVERT_READY,
    // AXI4-Lite slave
    input wire logic [adc_pkg::AXI_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [adc_pkg::AXI_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    // ==========================================
    // Pin synchronisers
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] din_s;
    logic [1:0] hardware_shutdown_n_s;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sclk_s <= 3'h0;
            cs_s <= 2'h3;
            din_s <= 2'h0;
            hardware_shutdown_n_s <= 2'h3;
        end else if (CE) begin
            sclk_s <= {sclk_s[1:0], SCLK};
            cs_s <= {cs_s[0], CS_B};
            din_s <= {din_s[0], DIN};
            hardware_shutdown_n_s <= {hardware_shutdown_n_s[0], HARDWARE_SHUTDOWN_N};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic din_bit;
    logic shutdown;
    assign sclk_rise = sclk_s[1] && !sclk_s[2];
    assign sclk_fall = !sclk_s[1] && sclk_s[2];
    assign selected = !cs_s[1];
    assign din_bit = din_s[1];
    assign shutdown = !hardware_shutdown_n_s[1];

    // ==========================================
    // Result buffer
    stream_if #(.W(adc_pkg::FIFO_W)) fill_bus ();
    stream_if #(.W(adc_pkg::FIFO_W)) drain_bus ();

    result_fifo #(
        .W(adc_pkg::FIFO_W),
        .DEPTH(adc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_b(RST_B),
        .ce(CE),
        .fill(fill_bus.sink),
        .drain(drain_bus.src)
    );

    // ==========================================
    // Serial sequencing and power state
    adc_pkg::serial_t state;
    adc_pkg::serial_t next_state;
    adc_pkg::power_sel_t mode;
    adc_pkg::power_sel_t next_mode;
    logic [adc_pkg::CNT_W-1:0] cnt;
    logic [adc_pkg::CNT_W-1:0] next_cnt;
    logic [7:0] shift_in;
    logic [7:0] next_shift_in;
    logic [7:0] last_byte;
    logic [7:0] next_last_byte;
    logic [adc_pkg::FRAME_BITS-1:0] shift_out;
    logic [adc_pkg::FRAME_BITS-1:0] next_shift_out;
    logic [adc_pkg::CODE_BITS-1:0] code;
    logic [adc_pkg::CODE_BITS-1:0] next_code;
    logic [adc_pkg::WAKE_W-1:0] wake_cnt;
    logic [adc_pkg::WAKE_W-1:0] next_wake_cnt;
    logic [adc_pkg::WAKE_W-1:0] wake_load;
    logic awake;
    logic next_awake;
    logic hw_sd;
    logic next_hw_sd;
    logic next_strobe;
    logic next_dout;
    logic next_oe_n;
    logic next_ready;
    logic [1:0] next_comp;
    logic next_ref;
    logic ext_ref;
    logic frame_done;

    assign frame_done = (state == adc_pkg::SER_SHIFT)
        && (cnt == adc_pkg::CNT_W'(adc_pkg::FRAME_BITS + 1));
    assign fill_bus.valid = frame_done;
    assign fill_bus.data = {last_byte[adc_pkg::CHAN_MSB:adc_pkg::CHAN_LSB], 3'h0, code};
    assign wake_load = ext_ref ? adc_pkg::WAKE_W'(adc_pkg::WAKE_CYC)
        : adc_pkg::WAKE_W'(REF_SETTLE_CYC);

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_cnt = cnt;
        next_shift_in = shift_in;
        next_last_byte = last_byte;
        next_shift_out = shift_out;
        next_code = code;
        next_awake = awake;
        next_hw_sd = 1'b0;
        next_strobe = CONVERSION_STROBE;
        next_dout = DOUT;
        next_wake_cnt = wake_cnt;
        if (shutdown) begin
            next_hw_sd = 1'b1;
            next_state = adc_pkg::SER_IDLE;
            next_awake = 1'b0;
            next_strobe = 1'b0;
            next_dout = 1'b0;
        end else if (!selected) begin
            next_state = adc_pkg::SER_IDLE;
            next_awake = 1'b0;
            next_strobe = 1'b0;
            next_dout = 1'b0;
        end else begin
            unique case (state)
                adc_pkg::SER_IDLE: begin
                    if (sclk_rise && din_bit) begin
                        next_shift_in = 8'h01;
                        next_cnt = adc_pkg::CNT_W'(1);
                        next_awake = 1'b1;
                        next_state = adc_pkg::SER_CONTROL;
                    end
                end
                adc_pkg::SER_CONTROL: begin
                    if (sclk_rise) begin
                        next_shift_in = {shift_in[6:0], din_bit};
                        next_cnt = cnt + 1'b1;
                        if (cnt == adc_pkg::CNT_W'(adc_pkg::CTRL_BITS - 1)) begin
                            next_last_byte = {shift_in[6:0], din_bit};
                            next_strobe = 1'b1;
                            next_state = adc_pkg::SER_STROBE;
                        end
                    end
                end
                adc_pkg::SER_STROBE: begin
                    if (sclk_fall) begin
                        next_strobe = 1'b0;
                        next_code = ANALOG_CODE;
                        next_shift_out = {ANALOG_CODE, adc_pkg::TAIL_BITS'(0)};
                        next_dout = ANALOG_CODE[adc_pkg::CODE_BITS-1];
                        next_cnt = adc_pkg::CNT_W'(1);
                        next_state = adc_pkg::SER_SHIFT;
                    end
                end
                adc_pkg::SER_SHIFT: begin
                    if (frame_done) begin
                        if (fill_bus.ready) begin
                            next_mode = adc_pkg::power_sel_t'(
                                last_byte[adc_pkg::PSEL_HIGH_BIT:adc_pkg::PSEL_LOW_BIT]);
                            next_awake = 1'b0;
                            next_dout = 1'b0;
                            next_state = adc_pkg::SER_IDLE;
                        end
                    end else if (cnt == adc_pkg::CNT_W'(adc_pkg::FRAME_BITS)) begin
                        if (sclk_rise) begin
                            next_cnt = cnt + 1'b1;
                        end
                    end else if (sclk_fall) begin
                        next_shift_out = {shift_out[adc_pkg::FRAME_BITS-2:0], 1'b0};
                        next_dout = shift_out[adc_pkg::FRAME_BITS-2];
                        next_cnt = cnt + 1'b1;
                    end
                end
            endcase
        end
        // Wake timer: reloads while powered fully down, runs after wake
        if (next_hw_sd || (!next_awake && next_mode == adc_pkg::FULL_POWER_DOWN_STATE)) begin
            next_wake_cnt = wake_load;
        end else if (wake_cnt != '0) begin
            next_wake_cnt = wake_cnt - 1'b1;
        end
        next_ready = (next_wake_cnt == '0) && !next_hw_sd;
        next_oe_n = !(selected && !shutdown);
        // Circuit power: off in shutdown, full while awake, else from the select code
        if (next_hw_sd) begin
            next_comp = adc_pkg::COMP_OFF;
            next_ref = 1'b0;
        end else if (next_awake) begin
            next_comp = adc_pkg::COMP_FULL;
            next_ref = 1'b1;
        end else begin
            unique case (next_mode)
                adc_pkg::FULL_POWER_DOWN_STATE: begin
                    next_comp = adc_pkg::COMP_OFF;
                    next_ref = 1'b0;
                end
                adc_pkg::FAST_POWER_DOWN_STATE, adc_pkg::REDUCED_POWER_STATE: begin
                    next_comp = adc_pkg::COMP_REDUCED;
                    next_ref = 1'b1;
                end
                adc_pkg::NORMAL_STATE: begin
                    next_comp = adc_pkg::COMP_FULL;
                    next_ref = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= adc_pkg::SER_IDLE;
            mode <= adc_pkg::NORMAL_STATE;
            cnt <= '0;
            shift_in <= 8'h00;
            last_byte <= 8'h00;
            shift_out <= '0;
            code <= '0;
            awake <= 1'b0;
            hw_sd <= 1'b0;
            wake_cnt <= adc_pkg::WAKE_W'(adc_pkg::WAKE_CYC);
            CONVERSION_STROBE <= 1'b0;
            DOUT <= 1'b0;
            DOUT_OE_N <= 1'b1;
            CONVERT_READY <= 1'b0;
            COMPARATOR_POWER <= adc_pkg::COMP_FULL;
            REFERENCE_ON <= 1'b1;
        end else if (CE) begin
            state <= next_state;
            mode <= next_mode;
            cnt <= next_cnt;
            shift_in <= next_shift_in;
            last_byte <= next_last_byte;
            shift_out <= next_shift_out;
            code <= next_code;
            awake <= next_awake;
            hw_sd <= next_hw_sd;
            wake_cnt <= next_wake_cnt;
            CONVERSION_STROBE <= next_strobe;
            DOUT <= next_dout;
            DOUT_OE_N <= next_oe_n;
            CONVERT_READY <= next_ready;
            COMPARATOR_POWER <= next_comp;
            REFERENCE_ON <= next_ref;
        end
    end

    assign CHANNEL_SELECT = last_byte[adc_pkg::CHAN_MSB:adc_pkg::CHAN_LSB];
    assign POLARITY_SELECT = last_byte[adc_pkg::POLARITY_BIT];
    assign INPUT_CONFIG_SELECT = last_byte[adc_pkg::CONFIG_BIT];
    assign FULLY_POWERED = awake;

    // ==========================================
    // AXI4-Lite register slave
    logic aw_held;
    logic w_held;
    logic [adc_pkg::AXI_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic next_aw_held;
    logic next_w_held;
    logic [adc_pkg::AXI_ADDR_W-1:0] next_waddr;
    logic [31:0] next_wdata;
    logic [3:0] next_wstrb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_ext_ref;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [adc_pkg::AXI_ADDR_W-1:0] raddr;
    logic [31:0] status;

    assign AWREADY = CE && !aw_held && !BVALID;
    assign WREADY = CE && !w_held && !BVALID;
    assign ARREADY = CE && !RVALID;
    assign raddr = {ARADDR[adc_pkg::AXI_ADDR_W-1:2], 2'b00};
    assign drain_bus.ready = ARVALID && ARREADY && (raddr == adc_pkg::REG_RESULT);

    always_comb begin
        status = 32'h00000000;
        status[adc_pkg::ST_MODE_LSB +: 2] = mode;
        status[adc_pkg::ST_AWAKE] = awake;
        status[adc_pkg::ST_SHUTDOWN] = hw_sd;
        status[adc_pkg::ST_READY] = CONVERT_READY;
        status[adc_pkg::ST_FIFO_NONEMPTY] = drain_bus.valid;
        status[adc_pkg::ST_FIFO_FULL] = !fill_bus.ready;
    end

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_waddr = waddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_bvalid = BVALID;
        next_bresp = BRESP;
        next_ext_ref = ext_ref;
        next_rvalid = RVALID;
        next_rdata = RDATA;
        next_rresp = RRESP;
        if (AWVALID && AWREADY) begin
            next_aw_held = 1'b1;
            next_waddr = {AWADDR[adc_pkg::AXI_ADDR_W-1:2], 2'b00};
        end
        if (WVALID && WREADY) begin
            next_w_held = 1'b1;
            next_wdata = WDATA;
            next_wstrb = WSTRB;
        end
        if (aw_held && w_held) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = adc_pkg::RESP_OKAY;
            if (waddr == adc_pkg::REG_CONTROL) begin
                if (wstrb[0]) begin
                    next_ext_ref = wdata[adc_pkg::CTL_EXT_REF];
                end
            end else if (waddr != adc_pkg::REG_STATUS && waddr != adc_pkg::REG_LAST_BYTE
                && waddr != adc_pkg::REG_RESULT) begin
                next_bresp = adc_pkg::RESP_SLVERR;
            end
        end else if (BVALID && BREADY) begin
            next_bvalid = 1'b0;
        end
        if (ARVALID && ARREADY) begin
            next_rvalid = 1'b1;
            next_rresp = adc_pkg::RESP_OKAY;
            next_rdata = 32'h00000000;
            unique case (raddr)
                adc_pkg::REG_STATUS: next_rdata = status;
                adc_pkg::REG_CONTROL: next_rdata = {31'h00000000, ext_ref};
                adc_pkg::REG_LAST_BYTE: next_rdata = {24'h000000, last_byte};
                adc_pkg::REG_RESULT: begin
                    if (drain_bus.valid) begin
                        next_rdata = {16'h0000, drain_bus.data};
                    end
                end
                default: next_rresp = adc_pkg::RESP_SLVERR;
            endcase
        end else if (RVALID && RREADY) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= '0;
            wdata <= 32'h00000000;
            wstrb <= 4'h0;
            BVALID <= 1'b0;
            BRESP <= adc_pkg::RESP_OKAY;
            ext_ref <= adc_pkg::CONTROL_EXT_REF_RESET;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= adc_pkg::RESP_OKAY;
        end else if (CE) begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            waddr <= next_waddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            BVALID <= next_bvalid;
            BRESP <= next_bresp;
            ext_ref <= next_ext_ref;
            RVALID <= next_rvalid;
            RDATA <= next_rdata;
            RRESP <= next_rresp;
        end
    end
endmodule

// [hdl/adc_pkg.sv]
package adc_pkg;
    // ==========================================
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int WAKE_TIME_NS = 2000;
    localparam int WAKE_CYC = (WAKE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int REF_SETTLE_US = 1200;
    localparam int REF_SETTLE_CYC = REF_SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int WAKE_W = 16;
    // ==========================================
    // Control byte layout and frame
    localparam int START_BIT = 7;
    localparam int CHAN_MSB = 6;
    localparam int CHAN_LSB = 4;
    localparam int POLARITY_BIT = 3;
    localparam int CONFIG_BIT = 2;
    localparam int PSEL_HIGH_BIT = 1;
    localparam int PSEL_LOW_BIT = 0;
    localparam int CTRL_BITS = 8;
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 10;
    localparam int TAIL_BITS = 6;
    localparam int CNT_W = 5;
    typedef enum logic [1:0] {
        FULL_POWER_DOWN_STATE = 2'b00,
        FAST_POWER_DOWN_STATE = 2'b01,
        REDUCED_POWER_STATE = 2'b10,
        NORMAL_STATE = 2'b11
    } power_sel_t;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_CONTROL = 2'b01,
        SER_STROBE = 2'b10,
        SER_SHIFT = 2'b11
    } serial_t;
    localparam logic [1:0] COMP_OFF = 2'b00;
    localparam logic [1:0] COMP_REDUCED = 2'b01;
    localparam logic [1:0] COMP_FULL = 2'b11;
    // ==========================================
    // Result buffer
    localparam int FIFO_W = 16;
    localparam int FIFO_DEPTH = 8;
    // ==========================================
    // Registers
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h04;
    localparam logic [7:0] REG_LAST_BYTE = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_AWAKE = 2;
    localparam int ST_SHUTDOWN = 3;
    localparam int ST_READY = 4;
    localparam int ST_FIFO_NONEMPTY = 5;
    localparam int ST_FIFO_FULL = 6;
    localparam int CTL_EXT_REF = 0;
    localparam logic CONTROL_EXT_REF_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [hdl/stream_if.sv]
`timescale 1ns/100ps
interface stream_if #(parameter int W = 16);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport sink(input data, input valid, output ready);
endinterface

// [hdl/result_fifo.sv]
`timescale 1ns/100ps
module result_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Streams
    stream_if.sink fill,
    stream_if.src drain
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign fill.ready = ce && (count != (AW+1)'(DEPTH));
    assign drain.valid = (count != '0);
    assign drain.data = mem[rd_ptr];
    assign push = fill.valid && fill.ready;
    assign pop = ce && drain.valid && drain.ready;

    // ==========================================
    // Pointers
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // ==========================================
    // Storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (push) begin
            mem[wr_ptr] <= fill.data;
        end
    end
endmodule

// [test/adc_power_mode_control_assertions.sv]
`timescale 1ns/100ps
module adc_power_mode_control_assertions (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_B,
    // Watched pins
    input wire logic CS_B,
    input wire logic HARDWARE_SHUTDOWN_N,
    input wire logic CONVERSION_STROBE,
    input wire logic FULLY_POWERED,
    input wire logic [1:0] COMPARATOR_POWER,
    input wire logic REFERENCE_ON,
    input wire logic CONVERT_READY,
    input wire logic DOUT_OE_N
);
    // ==========================================
    // Cycles since reset release
    logic [6:0] since_rst;
    logic [6:0] next_since_rst;
    always_comb begin
        next_since_rst = (since_rst == 7'h7F) ? since_rst : since_rst + 7'h01;
    end
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            since_rst <= 7'h00;
        end else begin
            since_rst <= next_since_rst;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // ==========================================
    // Checks
    shut_off_a: assert property (!HARDWARE_SHUTDOWN_N [*4] |->
        COMPARATOR_POWER == 2'b00 && !REFERENCE_ON && !CONVERT_READY) else $error("shutdown power");
    shut_abort_a: assert property ($fell(HARDWARE_SHUTDOWN_N) |->
        ##[1:4] !FULLY_POWERED && !CONVERSION_STROBE) else $error("shutdown abort");
    ref_track_a: assert property (REFERENCE_ON == (COMPARATOR_POWER != 2'b00))
        else $error("reference and comparator disagree");
    awake_full_a: assert property (FULLY_POWERED |-> COMPARATOR_POWER == 2'b11 && REFERENCE_ON)
        else $error("converting below full power");
    strobe_awake_a: assert property (CONVERSION_STROBE |-> FULLY_POWERED)
        else $error("strobe while not awake");
    wake_early_a: assert property (CONVERT_READY |-> since_rst >= 7'h48)
        else $error("ready too early");
    wake_late_a: assert property (since_rst == 7'h5A |-> CONVERT_READY)
        else $error("ready too late");
    dout_idle_a: assert property (CS_B [*4] |-> DOUT_OE_N)
        else $error("data out driven while deselected");
    cover property ($rose(CONVERSION_STROBE));
    cover property ($fell(HARDWARE_SHUTDOWN_N));
    cover property ($fell(FULLY_POWERED));
endmodule
bind adc_power_mode_control adc_power_mode_control_assertions chk (.*);

// [test/host_serial_model.sv]
`timescale 1ns/100ps
module host_serial_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic cs_b,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    logic lo_mode;
    initial begin
        lo_mode = 1'b0;
        cs_b = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // ==========================================
    // Control byte then readout, cut short after n rises
    task automatic frame(input logic [7:0] ctrl, input int n, output logic [15:0] rd);
        logic lo;
        rd = 16'h0000;
        lo = lo_mode || (ctrl[1] ^ ctrl[0]);
        @(posedge clk);
        cs_b <= 1'b0;
        din <= ctrl[7];
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge clk);
            @(negedge clk);
            if (i >= 8) rd = {rd[14:0], dout};
            @(posedge clk);
            sclk <= 1'b1;
            repeat (lo ? 5 : 4) @(posedge clk);
            sclk <= 1'b0;
            din <= (i < 7) ? ctrl[6 - i] : 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_b <= 1'b1;
        if (n >= 24) lo_mode = ctrl[1] ^ ctrl[0];
    endtask
endmodule

// [test/adc_power_mode_control_tb_top.sv]
`timescale 1ns/100ps
module adc_power_mode_control_tb_top;
    logic MCLK = 1'b0;
    logic RST_B = 1'b0;
    logic CE = 1'b1;
    logic HARDWARE_SHUTDOWN_N = 1'b1;
    logic [9:0] ANALOG_CODE = 10'h000;
    logic CS_B, SCLK, DIN, DOUT, DOUT_OE_N, CONVERSION_STROBE, POLARITY_SELECT;
    logic INPUT_CONFIG_SELECT, FULLY_POWERED, REFERENCE_ON, CONVERT_READY;
    logic [2:0] CHANNEL_SELECT;
    logic [1:0] COMPARATOR_POWER, BRESP, RRESP, rs;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [31:0] WDATA = 32'h0, RDATA, rd;
    logic [3:0] WSTRB = 4'hF;
    logic [15:0] fr;
    logic [2:0] pw_exp [4] = '{3'h0, 3'h3, 3'h3, 3'h7};
    int err_count = 0, compares = 0;
    always #12.5 MCLK = ~MCLK;
    adc_power_mode_control #(.REF_SETTLE_CYC(20)) dut (.*);
    host_serial_model host (
        .clk(MCLK),
        .cs_b(CS_B),
        .sclk(SCLK),
        .din(DIN),
        .dout(DOUT_OE_N ? !DOUT : DOUT)
    );
    // ==========================================
    // Helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge MCLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(negedge MCLK); while (ARREADY !== 1'b1);
        @(posedge MCLK) ARVALID <= 1'b0;
        do @(negedge MCLK); while (RVALID !== 1'b1);
        d = RDATA;
        r = RRESP;
        @(posedge MCLK) RREADY <= 1'b0;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa = 1'b1;
        logic pw = 1'b1;
        @(posedge MCLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (pa || pw) begin
            @(negedge MCLK);
            pa = pa && (AWREADY !== 1'b1);
            pw = pw && (WREADY !== 1'b1);
            @(posedge MCLK);
            AWVALID <= pa;
            WVALID <= pw;
        end
        do @(negedge MCLK); while (BVALID !== 1'b1);
        r = BRESP;
        @(posedge MCLK) BREADY <= 1'b0;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (4) @(posedge MCLK);
        RST_B <= 1'b1;
        repeat (10) @(posedge MCLK);
        check(32'(CONVERT_READY), 32'h0);
        repeat (90) @(posedge MCLK);
        check(32'({CONVERT_READY, COMPARATOR_POWER}), 32'h7);
        axi_rd(adc_pkg::REG_CONTROL, rd, rs);
        check(rd, 32'h1);
        check(32'(rs), 32'(adc_pkg::RESP_OKAY));
        $display("test wake done");
        for (int i = 0; i < 8; i++) begin
            @(posedge MCLK) ANALOG_CODE <= 10'(i * 146 + 1);
            host.frame({1'b1, 3'(i), 2'b10, 2'(i)}, 24, fr);
            check(32'(fr), 32'({10'(i * 146 + 1), 6'h00}));
            repeat (8) @(posedge MCLK);
            check(32'({FULLY_POWERED, COMPARATOR_POWER, REFERENCE_ON}), 32'(pw_exp[i % 4]));
            check(32'({CONVERT_READY, CHANNEL_SELECT}), 32'({i % 4 != 0, 3'(i)}));
            check(32'({POLARITY_SELECT, INPUT_CONFIG_SELECT}), 32'h2);
            axi_rd(adc_pkg::REG_STATUS, rd, rs);
            check(32'(rd[1:0]), 32'(i % 4));
        end
        check(32'(rd[adc_pkg::ST_FIFO_FULL]), 32'h1);
        for (int i = 0; i < 9; i++) begin
            axi_rd(adc_pkg::REG_RESULT, rd, rs);
            check(rd, (i < 8) ? 32'({3'(i), 3'b000, 10'(i * 146 + 1)}) : 32'h0);
        end
        axi_rd(8'h40, rd, rs);
        check(32'(rs), 32'(adc_pkg::RESP_SLVERR));
        $display("test modes done");
        host.frame(8'hF0, 12, fr);
        repeat (8) @(posedge MCLK);
        check(32'(COMPARATOR_POWER), 32'h3);
        $display("test abort done");
        axi_wr(adc_pkg::REG_CONTROL, 32'h0, rs);
        check(32'(rs), 32'(adc_pkg::RESP_OKAY));
        axi_rd(adc_pkg::REG_CONTROL, rd, rs);
        check(rd, 32'h0);
        fork
            host.frame(8'hF0, 24, fr);
            begin
                repeat (100) @(posedge MCLK);
                HARDWARE_SHUTDOWN_N <= 1'b0;
            end
        join
        check(32'({FULLY_POWERED, COMPARATOR_POWER, REFERENCE_ON, CONVERT_READY}), 32'h0);
        axi_rd(adc_pkg::REG_RESULT, rd, rs);
        check(rd, 32'h0);
        @(posedge MCLK) HARDWARE_SHUTDOWN_N <= 1'b1;
        repeat (35) @(posedge MCLK);
        check(32'(CONVERT_READY), 32'h1);
        $display("test shutdown done");
        close_out();
    end
    initial begin
        #500000;
        err_count++;
        close_out();
    end
endmodule
